// ==== irq_bank_map.svh ====
/*
  register offsets, field positions, reset values and bus answers of the
  peripheral interrupt enable and priority bank.
  assumes inclusion by bare name from files that decode the bank.
*/
`ifndef IRQ_BANK_MAP_SVH
`define IRQ_BANK_MAP_SVH
`define IRQB_OFF_EN_TWO 8'h00
`define IRQB_OFF_PR_ONE 8'h04
`define IRQB_OFF_PR_TWO 8'h08
`define IRQB_OFF_CTRL 8'h0c
`define IRQB_OFF_STATUS 8'h10
`define IRQB_OFF_MASK 8'h14
`define IRQB_RST_EN_TWO 8'h00
`define IRQB_RST_PR_ONE 8'hff
`define IRQB_RST_PR_TWO 8'hdf
`define IRQB_IMPL_TWO 8'hdf
`define IRQB_BIT_UNUSED 5
`define IRQB_CTL_LEVELS 7
`define IRQB_CTL_GROUP 6
`define IRQB_ST_HIGH 0
`define IRQB_ST_LOW 1
`define IRQB_RESP_OKAY 2'b00
`define IRQB_RESP_SLVERR 2'b10
`endif

// ==== irq_bank_pkg.sv ====
/*
  state types of the interrupt bank and its request router.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package irq_bank_pkg;
  typedef struct packed {
    logic [7:0] enTwo;
    logic [7:0] prOne;
    logic [7:0] prTwo;
    logic levelsOn;
    logic groupOn;
    logic [1:0] status;
    logic [1:0] mask;
    logic prevHigh;
    logic prevLow;
    logic irqOut;
    logic fresh;
    logic awHave;
    logic [7:0] awOff;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } bank_state_t;

  typedef struct packed {
    logic reqHigh;
    logic reqLow;
  } route_state_t;
endpackage
`default_nettype wire

// ==== irq_route_if.sv ====
/*
  carrier between the register bank and the request router.
  assumes the bank drives the source vectors and the router the requests.
*/
`timescale 1ns/1ps
`default_nettype none
interface irq_route_if;
  logic [15:0] pending;
  logic [15:0] enable;
  logic [15:0] prio;
  logic levelsOn;
  logic groupOn;
  logic reqHigh;
  logic reqLow;
  modport bank (output pending, output enable, output prio, output levelsOn,
                output groupOn, input reqHigh, input reqLow);
  modport router (input pending, input enable, input prio, input levelsOn,
                  input groupOn, output reqHigh, output reqLow);
endinterface
`default_nettype wire

// ==== irq_route.sv ====
/*
  request router: turns flagged and enabled sources into a high and a
  low level request toward the core, one cycle after its inputs.
  assumes all inputs are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_route
  import irq_bank_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  irq_route_if.router rif
);
  route_state_t st;
  route_state_t next_st;

  function automatic logic anyHit(input logic [15:0] a, input logic [15:0] b);
    anyHit = |(a & b);
  endfunction

  always_comb begin
    next_st = st;
    if (rif.levelsOn) begin
      next_st.reqHigh = anyHit(rif.pending & rif.enable, rif.prio);
      next_st.reqLow = anyHit(rif.pending & rif.enable, ~rif.prio);
    end else begin
      // priority bits ignored, one level only
      next_st.reqHigh = rif.groupOn && anyHit(rif.pending, rif.enable);
      next_st.reqLow = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rif.reqHigh = st.reqHigh;
  assign rif.reqLow = st.reqLow;
endmodule
`default_nettype wire

// ==== periph_irq_enable_priority_bank.sv ====
/*
  peripheral interrupt enable and priority bank behind an AXI4-Lite slave,
  with a request router toward the core and a sticky event interrupt.
  assumes flags and the first enable bank come from elsewhere, synchronous
  to sys_clk; one write and one read at most outstanding on the bus.
*/
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_map.svh"
// How it works
// - priority bits ignored unless levels are on
// - fifteen priority bits over two registers
// - second enable register, implemented bits reset zero
// - first priority register, all bits reset one
// - second priority register, bit five absent
// - priority one means high, zero low
// - unimplemented bits always read zero
// - each source has its own priority bit
// - one control bit turns priority levels on
// - levels off needs group enable set
module periph_irq_enable_priority_bank
  import irq_bank_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] flagOne,
  input wire logic [7:0] flagTwo,
  input wire logic [7:0] enableOne,
  output logic irqHigh,
  output logic irqLow,
  output logic priorityLevelsOn,
  output logic groupIrqOn,
  output logic irq
);
  localparam bank_state_t RESET_ST = '{
    enTwo: `IRQB_RST_EN_TWO,
    prOne: `IRQB_RST_PR_ONE,
    prTwo: `IRQB_RST_PR_TWO,
    fresh: 1'b1,
    default: '0
  };

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_check
    $error("ADDR_W must lie between 8 and 32");
  end

  bank_state_t st;
  bank_state_t next_st;
  logic doWrite;
  logic [1:0] events;
  logic [1:0] w1c;
  logic [15:0] active;
  logic [7:0] wByte;
  logic wLevel;
  logic wGroup;
  logic [1:0] wLow;
  logic wMapped;
  logic singleGate;

  irq_route_if rif();

  irq_route u_route (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .rif(rif)
  );

  function automatic logic offMapped(input logic [7:0] off);
    offMapped = off == `IRQB_OFF_EN_TWO || off == `IRQB_OFF_PR_ONE ||
                off == `IRQB_OFF_PR_TWO || off == `IRQB_OFF_CTRL ||
                off == `IRQB_OFF_STATUS || off == `IRQB_OFF_MASK;
  endfunction

  function automatic logic [7:0] regValue(input bank_state_t s, input logic [7:0] off);
    logic [7:0] v;
    v = 8'h00;
    case (off)
      `IRQB_OFF_EN_TWO: begin
        v = s.enTwo & `IRQB_IMPL_TWO;
      end
      `IRQB_OFF_PR_ONE: begin
        v = s.prOne;
      end
      `IRQB_OFF_PR_TWO: begin
        v = s.prTwo & `IRQB_IMPL_TWO;
      end
      `IRQB_OFF_CTRL: begin
        v[`IRQB_CTL_LEVELS] = s.levelsOn;
        v[`IRQB_CTL_GROUP] = s.groupOn;
      end
      `IRQB_OFF_STATUS: begin
        v[1:0] = s.status;
      end
      `IRQB_OFF_MASK: begin
        v[1:0] = s.mask;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // flags of absent sources are dropped before routing
  assign rif.pending = {flagTwo & `IRQB_IMPL_TWO, flagOne};
  assign rif.enable = {st.enTwo, enableOne};
  assign rif.prio = {st.prTwo, st.prOne};
  assign rif.levelsOn = st.levelsOn;
  assign rif.groupOn = st.groupOn;

  // a pending response blocks new writes, keeping one write in flight
  assign awready = !st.awHave && !st.bValid;
  assign wready = !st.wHave && !st.bValid;
  assign arready = !st.rValid;
  assign doWrite = st.awHave && st.wHave && !st.bValid;

  always_comb begin
    next_st = st;
    w1c = 2'b00;
    events = 2'b00;
    next_st.fresh = 1'b0;
    if (awvalid && awready) begin
      next_st.awHave = 1'b1;
      next_st.awOff = awaddr[7:0];
    end
    if (wvalid && wready) begin
      next_st.wHave = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (doWrite) begin
      next_st.awHave = 1'b0;
      next_st.wHave = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = offMapped(st.awOff) ? `IRQB_RESP_OKAY : `IRQB_RESP_SLVERR;
      // registers sit in byte lane zero only
      if (st.wStrb[0]) begin
        case (st.awOff)
          `IRQB_OFF_EN_TWO: begin
            next_st.enTwo = st.wData[7:0] & `IRQB_IMPL_TWO;
          end
          `IRQB_OFF_PR_ONE: begin
            next_st.prOne = st.wData[7:0];
          end
          `IRQB_OFF_PR_TWO: begin
            next_st.prTwo = st.wData[7:0] & `IRQB_IMPL_TWO;
          end
          `IRQB_OFF_CTRL: begin
            next_st.levelsOn = st.wData[`IRQB_CTL_LEVELS];
            next_st.groupOn = st.wData[`IRQB_CTL_GROUP];
          end
          `IRQB_OFF_STATUS: begin
            w1c = st.wData[1:0];
          end
          `IRQB_OFF_MASK: begin
            next_st.mask = st.wData[1:0];
          end
          default: begin
            w1c = 2'b00;
          end
        endcase
      end
    end
    if (st.bValid && bready) begin
      next_st.bValid = 1'b0;
    end
    if (arvalid && arready) begin
      next_st.rValid = 1'b1;
      next_st.rData = {24'h000000, regValue(st, araddr[7:0])};
      next_st.rResp = offMapped(araddr[7:0]) ? `IRQB_RESP_OKAY : `IRQB_RESP_SLVERR;
    end else if (st.rValid && rready) begin
      next_st.rValid = 1'b0;
    end
    events[`IRQB_ST_HIGH] = rif.reqHigh && !st.prevHigh;
    events[`IRQB_ST_LOW] = rif.reqLow && !st.prevLow;
    // a new event outranks a clear in the same cycle
    next_st.status = (st.status & ~w1c) | events;
    next_st.prevHigh = rif.reqHigh;
    next_st.prevLow = rif.reqLow;
    next_st.irqOut = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  assign bvalid = st.bValid;
  assign bresp = st.bResp;
  assign rvalid = st.rValid;
  assign rdata = st.rData;
  assign rresp = st.rResp;
  assign irqHigh = rif.reqHigh;
  assign irqLow = rif.reqLow;
  assign priorityLevelsOn = st.levelsOn;
  assign groupIrqOn = st.groupOn;
  assign irq = st.irqOut;

  assign active = rif.pending & rif.enable;
  assign wByte = st.wData[7:0];
  assign wLevel = st.wData[`IRQB_CTL_LEVELS];
  assign wGroup = st.wData[`IRQB_CTL_GROUP];
  assign wLow = st.wData[1:0];
  assign wMapped = offMapped(st.awOff);
  // sampled-value functions take a plain signal, so the gate gets a name
  assign singleGate = st.groupOn && (|active);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  compat_single_level_a: assert property (
    !st.levelsOn |=> !irqLow
  ) else $error("low request raised while priority levels are off");

  prio_vector_a: assert property (
    rif.prio == {st.prTwo, st.prOne}
  ) else $error("priority vector does not match the two registers");

  en_two_write_a: assert property (
    (doWrite && st.wStrb[0] && st.awOff == `IRQB_OFF_EN_TWO)
    |=> st.enTwo == ($past(wByte) & `IRQB_IMPL_TWO)
  ) else $error("second enable register missed a write");

  reset_values_a: assert property (
    st.fresh |-> (st.enTwo == `IRQB_RST_EN_TWO && st.prOne == `IRQB_RST_PR_ONE &&
                  st.prTwo == `IRQB_RST_PR_TWO && !st.levelsOn)
  ) else $error("bank left reset with wrong values");

  unimpl_zero_a: assert property (
    !st.enTwo[`IRQB_BIT_UNUSED] && !st.prTwo[`IRQB_BIT_UNUSED] &&
    (!st.rValid || st.rData[31:8] == 24'h000000)
  ) else $error("unimplemented bit reads as one");

  high_route_a: assert property (
    (st.levelsOn && |(active & rif.prio)) |=> irqHigh
  ) else $error("high priority source not routed high");

  low_route_a: assert property (
    (st.levelsOn && |(active & ~rif.prio)) |=> irqLow
  ) else $error("low priority source not routed low");

  prio_write_a: assert property (
    (doWrite && st.wStrb[0] && st.awOff == `IRQB_OFF_PR_ONE)
    |=> st.prOne == $past(wByte)
  ) else $error("first priority register missed a write");

  ctrl_write_a: assert property (
    (doWrite && st.wStrb[0] && st.awOff == `IRQB_OFF_CTRL)
    |=> st.levelsOn == $past(wLevel)
  ) else $error("priority level control missed a write");

  group_gate_a: assert property (
    !st.levelsOn |=> irqHigh == $past(singleGate)
  ) else $error("single level request ignores the group enable");

  no_source_quiet_a: assert property (
    !(|active) |=> !irqHigh && !irqLow
  ) else $error("request raised with no flagged enabled source");

  sticky_event_a: assert property (
    events[`IRQB_ST_HIGH] |=> st.status[`IRQB_ST_HIGH] && irq == |(st.status & st.mask)
  ) else $error("event lost or interrupt level wrong");

  pr_two_write_a: assert property (
    (doWrite && st.wStrb[0] && st.awOff == `IRQB_OFF_PR_TWO)
    |=> st.prTwo == ($past(wByte) & `IRQB_IMPL_TWO)
  ) else $error("second priority register missed a write");

  group_write_a: assert property (
    (doWrite && st.wStrb[0] && st.awOff == `IRQB_OFF_CTRL)
    |=> st.groupOn == $past(wGroup)
  ) else $error("group enable control missed a write");

  mask_write_a: assert property (
    (doWrite && st.wStrb[0] && st.awOff == `IRQB_OFF_MASK)
    |=> st.mask == $past(wLow)
  ) else $error("mask register missed a write");

  write_resp_a: assert property (
    doWrite |=> bvalid && bresp == ($past(wMapped) ? `IRQB_RESP_OKAY : `IRQB_RESP_SLVERR)
  ) else $error("write answer missing or with the wrong code");

  read_answer_a: assert property (
    (arvalid && arready) |=> rvalid
  ) else $error("read answer missing");

  status_clear_a: assert property (
    (doWrite && st.wStrb[0] && st.awOff == `IRQB_OFF_STATUS && events == 2'b00)
    |=> (st.status & $past(wLow)) == 2'b00
  ) else $error("status bit survived a clear");

  set_wins_a: assert property (
    events[`IRQB_ST_LOW] |=> st.status[`IRQB_ST_LOW]
  ) else $error("low request event lost");

  masked_quiet_a: assert property (
    st.mask == 2'b00 |-> !irq
  ) else $error("interrupt raised with every status bit masked");

  unmapped_write_a: assert property (
    (doWrite && !wMapped)
    |=> $stable(st.enTwo) && $stable(st.prOne) && $stable(st.prTwo) && $stable(st.mask)
  ) else $error("write to an unmapped offset changed a register");

  read_prio_a: assert property (
    (arvalid && arready && araddr[7:0] == `IRQB_OFF_PR_ONE)
    |=> rdata[7:0] == $past(st.prOne)
  ) else $error("first priority register read back wrong");

  read_unused_a: assert property (
    (arvalid && arready && (araddr[7:0] == `IRQB_OFF_PR_TWO || araddr[7:0] == `IRQB_OFF_EN_TWO))
    |=> !rdata[`IRQB_BIT_UNUSED]
  ) else $error("absent bit five read as one");

  high_quiet_a: assert property (
    (st.levelsOn && !(|(active & rif.prio))) |=> !irqHigh
  ) else $error("high request without a high priority source");

  low_quiet_a: assert property (
    (st.levelsOn && !(|(active & ~rif.prio))) |=> !irqLow
  ) else $error("low request without a low priority source");

  write_ctrl_c: cover property (doWrite && st.awOff == `IRQB_OFF_CTRL ##1 st.levelsOn);
  low_request_c: cover property (st.levelsOn ##1 $rose(irqLow));
  irq_rise_c: cover property ($rose(irq));
  bad_read_c: cover property (st.rValid && st.rResp == `IRQB_RESP_SLVERR);
  status_clear_c: cover property (doWrite && st.awOff == `IRQB_OFF_STATUS);
endmodule
`default_nettype wire

// ==== core_model.sv ====
/*
  core side model: latches the level requests that the bank raises.
  assumes requests are levels synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic irqHigh,
  input wire logic irqLow,
  output logic [1:0] served
);
  // requests are levels, so one flop shows what the core would vector to
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      served <= 2'h0;
    end else begin
      served <= {irqHigh, irqLow};
    end
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
/*
  self-checking bench of the interrupt bank over AXI4-Lite.
  assumes the map header and a core model beside the bank.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_map.svh"
module testbench;
  localparam logic [7:0] EN2 = `IRQB_OFF_EN_TWO;
  localparam logic [7:0] PR1 = `IRQB_OFF_PR_ONE;
  localparam logic [7:0] PR2 = `IRQB_OFF_PR_TWO;
  localparam logic [7:0] CTL = `IRQB_OFF_CTRL;
  localparam logic [7:0] STA = `IRQB_OFF_STATUS;
  localparam logic [7:0] MSK = `IRQB_OFF_MASK;
  localparam logic [1:0] OK = `IRQB_RESP_OKAY;
  localparam logic [1:0] ERR = `IRQB_RESP_SLVERR;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, flagOne = 8'h00, flagTwo = 8'h00, enableOne = 8'h00, v;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rnd;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, irqHigh, irqLow, levels, group, irq;
  logic [1:0] bresp, rresp, served;
  logic [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int nFail = 0;
  int cmpCount = 0;
  int seed = 32'h14b87a49;
  always #12.5 sys_clk = ~sys_clk;
  periph_irq_enable_priority_bank #(.ADDR_W(8)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .flagOne(flagOne), .flagTwo(flagTwo),
    .enableOne(enableOne), .irqHigh(irqHigh), .irqLow(irqLow), .priorityLevelsOn(levels),
    .groupIrqOn(group), .irq(irq));
  core_model i_core (.sys_clk(sys_clk), .rst_b(rst_b), .irqHigh(irqHigh), .irqLow(irqLow),
    .served(served));
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // answers stand one cycle with ready held high, so a negedge sees each once
  always @(negedge sys_clk) begin
    if (rvalid === 1'b1) check({rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1) check({32'h0, bresp}, {32'h0, bq.pop_front()});
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(negedge sys_clk);
    while (!(awready && wready)) @(negedge sys_clk);
    @(posedge sys_clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(negedge sys_clk);
    while (!bvalid) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    rq.push_back({r, 24'h0, d});
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    @(negedge sys_clk);
    while (!arready) @(negedge sys_clk);
    @(posedge sys_clk);
    arvalid <= 1'b0;
    @(negedge sys_clk);
    while (!rvalid) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  // one edge in the bank and one in the core model; three leaves margin
  task automatic req(input logic [7:0] f1, input logic [7:0] f2, input logic [7:0] e1, input logic [1:0] e);
    @(posedge sys_clk);
    flagOne <= f1;
    flagTwo <= f2;
    enableOne <= e1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check({32'h0, served}, {32'h0, e});
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check({33'h0, irq}, {33'h0, e});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(EN2, 8'h00, OK);
    rd(PR1, 8'hff, OK);
    rd(PR2, 8'hdf, OK);
    rd(CTL, 8'h00, OK);
    rd(8'h40, 8'h00, ERR);
    wr(8'h40, 8'hff, ERR);
    wr(EN2, 8'hff, OK);
    rd(EN2, 8'hdf, OK);
    wr(PR2, 8'h00, OK);
    wr(PR2, 8'hff, OK);
    rd(PR2, 8'hdf, OK);
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      v = rnd[7:0];
      wr(PR1, v, OK);
      rd(PR1, v, OK);
    end
    wr(CTL, 8'h80, OK);
    @(negedge sys_clk);
    check({32'h0, levels, group}, {32'h0, 2'b10});
    wr(PR1, 8'h01, OK);
    req(8'h01, 8'h00, 8'h01, 2'b10);
    req(8'h02, 8'h00, 8'h02, 2'b01);
    req(8'h03, 8'h00, 8'h00, 2'b00);
    wr(EN2, 8'h01, OK);
    wr(PR2, 8'h00, OK);
    req(8'h00, 8'h21, 8'h00, 2'b01);
    wr(CTL, 8'h00, OK);
    req(8'h02, 8'h00, 8'h02, 2'b00);
    wr(CTL, 8'h40, OK);
    @(negedge sys_clk);
    check({32'h0, levels, group}, {32'h0, 2'b01});
    req(8'h02, 8'h00, 8'h02, 2'b10);
    // both requests rose earlier while masked; status is sticky
    rd(STA, 8'h03, OK);
    wr(MSK, 8'h03, OK);
    irq_is(1'b1);
    wr(STA, 8'h03, OK);
    irq_is(1'b0);
    req(8'h00, 8'h00, 8'h02, 2'b00);
    req(8'h02, 8'h00, 8'h02, 2'b10);
    irq_is(1'b1);
    wr(MSK, 8'h00, OK);
    irq_is(1'b0);
    rd(STA, 8'h01, OK);
    tally_and_finish();
  end
  initial begin
    #100000;
    nFail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
